// file: core/ptap_pkg.sv
// constants for the pulse event flag and threshold block
package ptap_pkg;
    localparam int PTAP_AW = 8;
    localparam int PTAP_DW = 8;
    localparam logic [7:0] PTAP_ADDR_CFG = 8'h21;
    localparam logic [7:0] PTAP_ADDR_STATUS = 8'h22;
    localparam logic [7:0] PTAP_ADDR_THSX = 8'h23;
    localparam logic [7:0] PTAP_ADDR_THSY = 8'h24;
    localparam logic [7:0] PTAP_ADDR_THSZ = 8'h25;
    localparam logic [7:0] PTAP_ADDR_TMLT = 8'h26;
    localparam logic [7:0] PTAP_ADDR_LTCY = 8'h27;
    localparam logic [7:0] PTAP_ADDR_IMASK = 8'h28;
    localparam logic [7:0] PTAP_RESET_VAL = 8'h00;
    localparam int PTAP_CFG_LATCH = 6;
    localparam int PTAP_CFG_ABORT = 7;
    localparam int PTAP_ST_ACTIVE = 7;
    localparam int PTAP_ST_AXZ = 6;
    localparam int PTAP_ST_AXY = 5;
    localparam int PTAP_ST_AXX = 4;
    localparam int PTAP_ST_DOUBLE = 3;
    localparam int PTAP_ST_POLZ = 2;
    localparam int PTAP_ST_POLY = 1;
    localparam int PTAP_ST_POLX = 0;
    localparam int PTAP_THS_W = 7;
    localparam int PTAP_AXES = 3;
    // threshold lsb weight in milli-g, full scale fixed at 8 g
    localparam int PTAP_THS_MG_PER_LSB = 63;
    localparam int PTAP_THS_RANGE_G = 8;
    localparam int PTAP_SAMPLE_W = 14;
    // 0.063 g per lsb on 8 g scale: sample lsb is 8g/8192, so 64 per step
    localparam int PTAP_THS_SHIFT = 6;
    localparam logic [7:0] PTAP_TMR_ZERO = 8'h00;
    localparam logic [7:0] PTAP_TMR_ONE = 8'h01;
    typedef enum logic [3:0] {
        PTAP_IDLE = 4'h1,
        PTAP_ABOVE = 4'h2,
        PTAP_LATENT = 4'h4,
        PTAP_WAIT2 = 4'h8
    } ptap_state_t;
endpackage : ptap_pkg

// file: core/ptap_axis.sv
// one axis: threshold compare and pulse width timing
module ptap_axis
    import ptap_pkg::*;
#(
    parameter int SW = PTAP_SAMPLE_W
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sample_en_i,
    input wire logic signed [SW-1:0] sample_i,
    input wire logic [PTAP_THS_W-1:0] ths_i,
    input wire logic [7:0] tmlt_i,
    output logic pulse_o,
    output logic neg_o
);
    logic signed [SW-1:0] mag_pos;
    logic [SW-1:0] mag;
    logic [SW-1:0] ths_wide;
    logic above;
    logic in_reg;
    logic sign_reg;
    logic [7:0] cnt_reg;
    assign mag_pos = sample_i[SW-1] ? -sample_i : sample_i;
    assign mag = SW'(mag_pos);
    // threshold scaled against a fixed 8 g range
    assign ths_wide = SW'({ths_i, {PTAP_THS_SHIFT{1'b0}}});
    assign above = (mag > ths_wide);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_reg <= 1'b0;
            sign_reg <= 1'b0;
            cnt_reg <= PTAP_TMR_ZERO;
            pulse_o <= 1'b0;
            neg_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (sample_en_i) begin
                if (!in_reg && above) begin
                    in_reg <= 1'b1;
                    sign_reg <= sample_i[SW-1];
                    cnt_reg <= PTAP_TMR_ZERO;
                end else if (in_reg && !above) begin
                    in_reg <= 1'b0;
                    // counts only if it fell back within the limit
                    pulse_o <= (cnt_reg < tmlt_i);
                    neg_o <= sign_reg;
                end else if (in_reg && cnt_reg != 8'hFF) begin
                    cnt_reg <= cnt_reg + PTAP_TMR_ONE;
                end
            end
        end
    end
endmodule : ptap_axis

// file: core/ptap_top.sv
// pulse event flags, status and thresholds with register port
// How it works
// - double-pulse flag per axis raised only when its enable bit 5/3/1 set
// - single-pulse flag per axis raised only when its enable bit 4/2/0 set
// - status bit 7 set when an enabled pulse event occurred, else zero
// - status bits 6/5/4 mark Z/Y/X axes where an event occurred
// - status bit 3 is zero for single, one for double event
// - status bits 2/1/0 give Z/Y/X pulse sign, one means negative
// - status register is read-only and resets to zero
// - each axis has its own 7-bit threshold starting detection
// - thresholds are unsigned 7-bit at 0.063 g per lsb
// - thresholds scale on fixed 8 g regardless of output range
// - three threshold registers reset to zero, read and writable
// - with latch enable, flags hold until status read clears them
// - pulse counts only if it drops below threshold within time limit
// - after first pulse with a double enable set, pulses ending in latency time are ignored
module ptap_top
    import ptap_pkg::*;
#(
    parameter int SW = PTAP_SAMPLE_W,
    parameter logic [7:0] WINDOW_STEPS = 8'hFF
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sample_en_i,
    input wire logic signed [SW-1:0] accel_x_i,
    input wire logic signed [SW-1:0] accel_y_i,
    input wire logic signed [SW-1:0] accel_z_i,
    input wire logic [PTAP_AW-1:0] reg_addr_i,
    input wire logic [PTAP_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [PTAP_DW-1:0] reg_rdata_o,
    output logic irq_o
);
    logic [7:0] cfg_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] mask_reg;
    logic [7:0] tmlt_reg;
    logic [7:0] ltcy_reg;
    logic [PTAP_THS_W-1:0] ths_reg [PTAP_AXES];
    logic [7:0] tmr_reg;
    ptap_state_t state_reg;
    ptap_state_t state_next;
    logic [PTAP_AXES-1:0] pulse;
    logic [PTAP_AXES-1:0] neg;
    logic [PTAP_AXES-1:0] first_ax_reg;
    logic signed [SW-1:0] accel [PTAP_AXES];
    logic [PTAP_AXES-1:0] en_single;
    logic [PTAP_AXES-1:0] en_double;
    logic [PTAP_AXES-1:0] hit_single;
    logic [PTAP_AXES-1:0] hit_double;
    logic any_pulse;
    logic fire_single;
    logic fire_double;
    logic fire;
    logic [PTAP_AXES-1:0] fire_ax;
    logic tmr_done;
    logic eval_reg;
    logic wr_cfg;
    logic wr_mask;
    logic wr_tmlt;
    logic wr_ltcy;
    logic rd_status;
    logic [7:0] rd_mux;
    logic [7:0] ev_bits;

    assign accel[0] = accel_x_i;
    assign accel[1] = accel_y_i;
    assign accel[2] = accel_z_i;

    // config bits per axis: x at 1:0, y at 3:2, z at 5:4
    genvar g;
    generate
        for (g = 0; g < PTAP_AXES; g++) begin : g_axis
            ptap_axis #(.SW(SW)) u_axis (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .sample_en_i(sample_en_i),
                .sample_i(accel[g]),
                .ths_i(ths_reg[g]),
                .tmlt_i(tmlt_reg),
                .pulse_o(pulse[g]),
                .neg_o(neg[g])
            );
            assign en_single[g] = cfg_reg[2*g];
            assign en_double[g] = cfg_reg[2*g+1];
            assign hit_single[g] = pulse[g] && en_single[g];
            assign hit_double[g] = pulse[g] && en_double[g]
                && first_ax_reg[g];
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    ths_reg[g] <= PTAP_THS_W'(PTAP_RESET_VAL);
                end else if (reg_wr_i && reg_addr_i ==
                        PTAP_ADDR_THSX + 8'(g)) begin
                    ths_reg[g] <= reg_wdata_i[PTAP_THS_W-1:0];
                end
            end
        end
    endgenerate

    assign any_pulse = |pulse;
    assign tmr_done = (tmr_reg == PTAP_TMR_ZERO);
    // a single fires on the first pulse; double needs second in window
    assign fire_single = (state_reg == PTAP_IDLE) && (|hit_single);
    assign fire_double = (state_reg == PTAP_WAIT2) && (|hit_double);
    assign fire = fire_single || fire_double;
    assign fire_ax = fire_double ? hit_double : hit_single;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PTAP_IDLE: begin
                if (any_pulse && (|en_double))
                    state_next = PTAP_LATENT;
            end
            PTAP_ABOVE: state_next = PTAP_IDLE;
            PTAP_LATENT: begin
                // pulses during latency are ignored
                if (tmr_done)
                    state_next = PTAP_WAIT2;
            end
            PTAP_WAIT2: begin
                if (any_pulse || tmr_done)
                    state_next = PTAP_IDLE;
            end
            default: state_next = PTAP_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= PTAP_IDLE;
            tmr_reg <= PTAP_TMR_ZERO;
            first_ax_reg <= '0;
        end else if (eval_reg) begin
            state_reg <= state_next;
            if (state_reg == PTAP_IDLE && state_next == PTAP_LATENT) begin
                tmr_reg <= ltcy_reg;
                first_ax_reg <= pulse;
            end else if (state_reg == PTAP_LATENT && tmr_done) begin
                tmr_reg <= WINDOW_STEPS;
            end else if (!tmr_done) begin
                tmr_reg <= tmr_reg - PTAP_TMR_ONE;
            end
        end
    end

    // axis pulses land one cycle after the sample strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            eval_reg <= 1'b0;
        else
            eval_reg <= sample_en_i;
    end

    // event bits in status layout
    assign ev_bits = {1'b1, fire_ax[2], fire_ax[1], fire_ax[0],
        fire_double, neg[2] & fire_ax[2], neg[1] & fire_ax[1],
        neg[0] & fire_ax[0]};

    assign rd_status = reg_rd_i && (reg_addr_i == PTAP_ADDR_STATUS);
    assign wr_cfg = reg_wr_i && (reg_addr_i == PTAP_ADDR_CFG);
    assign wr_mask = reg_wr_i && (reg_addr_i == PTAP_ADDR_IMASK);
    assign wr_tmlt = reg_wr_i && (reg_addr_i == PTAP_ADDR_TMLT);
    assign wr_ltcy = reg_wr_i && (reg_addr_i == PTAP_ADDR_LTCY);

    // a new event wins over a clearing read in the same cycle
    always_comb begin
        status_next = status_reg;
        if (cfg_reg[PTAP_CFG_LATCH]) begin
            if (rd_status)
                status_next = PTAP_RESET_VAL;
        end else if (eval_reg) begin
            status_next = PTAP_RESET_VAL;
        end
        if (eval_reg && fire) begin
            if (cfg_reg[PTAP_CFG_LATCH] && !rd_status)
                status_next = status_reg | ev_bits;
            else
                status_next = ev_bits;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_reg <= PTAP_RESET_VAL;
            status_reg <= PTAP_RESET_VAL;
            mask_reg <= PTAP_RESET_VAL;
            tmlt_reg <= PTAP_RESET_VAL;
            ltcy_reg <= PTAP_RESET_VAL;
        end else begin
            status_reg <= status_next;
            if (wr_cfg)
                cfg_reg <= reg_wdata_i;
            if (wr_mask)
                mask_reg <= reg_wdata_i;
            if (wr_tmlt)
                tmlt_reg <= reg_wdata_i;
            if (wr_ltcy)
                ltcy_reg <= reg_wdata_i;
        end
    end

    always_comb begin
        rd_mux = PTAP_RESET_VAL;
        unique case (reg_addr_i)
            PTAP_ADDR_CFG: rd_mux = cfg_reg;
            PTAP_ADDR_STATUS: rd_mux = status_reg;
            PTAP_ADDR_THSX: rd_mux = {1'b0, ths_reg[0]};
            PTAP_ADDR_THSY: rd_mux = {1'b0, ths_reg[1]};
            PTAP_ADDR_THSZ: rd_mux = {1'b0, ths_reg[2]};
            PTAP_ADDR_TMLT: rd_mux = tmlt_reg;
            PTAP_ADDR_LTCY: rd_mux = ltcy_reg;
            PTAP_ADDR_IMASK: rd_mux = mask_reg;
            default: rd_mux = PTAP_RESET_VAL;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            reg_rdata_o <= PTAP_RESET_VAL;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
        else
            reg_rdata_o <= PTAP_RESET_VAL;
    end

    assign irq_o = |(status_reg & mask_reg);

    a_status_ro: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_wr_i && reg_addr_i == PTAP_ADDR_STATUS && !eval_reg
         && !rd_status) |=> $stable(status_reg))
        else $error("status changed by a write");
    a_ea_cause: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(status_reg[PTAP_ST_ACTIVE]) |-> $past(fire && eval_reg))
        else $error("event active without event");
    // a fresh single event may only name single-enabled axes
    a_single_en: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ($rose(status_reg[PTAP_ST_ACTIVE]) && !status_reg[PTAP_ST_DOUBLE])
        |-> (status_reg[PTAP_ST_AXZ:PTAP_ST_AXX] & ~$past(en_single))
        == 3'h0)
        else $error("single fired while disabled");
    a_double_en: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ($rose(status_reg[PTAP_ST_ACTIVE]) && status_reg[PTAP_ST_DOUBLE])
        |-> (status_reg[PTAP_ST_AXZ:PTAP_ST_AXX] & ~$past(en_double))
        == 3'h0)
        else $error("double fired while disabled");
    a_axis_src: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (eval_reg && fire && !cfg_reg[PTAP_CFG_LATCH]) |=>
        status_reg[PTAP_ST_AXZ:PTAP_ST_AXX] == $past(fire_ax))
        else $error("axis source mismatch");
    a_kind_bit: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (eval_reg && fire && !cfg_reg[PTAP_CFG_LATCH]) |=>
        status_reg[PTAP_ST_DOUBLE] == $past(fire_double))
        else $error("double bit mismatch");
    a_latch_hold: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cfg_reg[PTAP_CFG_LATCH] && !rd_status && !fire && !wr_cfg)
        |=> status_reg == $past(status_reg))
        else $error("latched flags lost");
    a_read_clear: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (cfg_reg[PTAP_CFG_LATCH] && rd_status && !(eval_reg && fire))
        |=> status_reg == PTAP_RESET_VAL)
        else $error("read did not clear");
    // unlatched flags live for one sample period only
    a_nolatch_clr: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (eval_reg && !fire && !cfg_reg[PTAP_CFG_LATCH])
        |=> status_reg == PTAP_RESET_VAL)
        else $error("unlatched flags outlived the sample");
    a_ths_msb: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (reg_rd_i && reg_addr_i >= PTAP_ADDR_THSX
         && reg_addr_i <= PTAP_ADDR_THSZ) |=> !reg_rdata_o[7])
        else $error("threshold bit 7 nonzero");
    a_latency: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_reg == PTAP_LATENT) |-> !fire)
        else $error("fired during latency");
endmodule : ptap_top

// file: tb/ptap_top_test.sv
// self-checking bench for the pulse event flag and threshold block
`define CHK(nm, e, g) \
    cmp_count++; \
    if ((g) !== (e)) begin \
        $display("FAIL %s expected %h seen %h", nm, e, g); \
        error_cnt++; \
    end

module ptap_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ptap_pkg::*;
    localparam int SW = PTAP_SAMPLE_W;
    logic clk_i;
    logic arst_n_i;
    logic sample_en_i;
    logic signed [SW-1:0] ax;
    logic signed [SW-1:0] ay;
    logic signed [SW-1:0] az;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic irq_o;
    int error_cnt;
    int cmp_count;

    // short window keeps the double-pulse case brief
    ptap_top #(.SW(SW), .WINDOW_STEPS(8'h04)) dut (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sample_en_i(sample_en_i),
        .accel_x_i(ax),
        .accel_y_i(ay),
        .accel_z_i(az),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // read data valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata_o)
    endtask : rd

    task automatic smp(input int x, input int y, input int z);
        @(posedge clk_i);
        ax <= x[SW-1:0];
        ay <= y[SW-1:0];
        az <= z[SW-1:0];
        sample_en_i <= 1'b1;
        @(posedge clk_i);
        sample_en_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : smp

    task automatic setup(input logic [7:0] cfg, input logic [7:0] tx,
                         input logic [7:0] ty, input logic [7:0] tz);
        wr(PTAP_ADDR_CFG, cfg);
        wr(PTAP_ADDR_THSX, tx);
        wr(PTAP_ADDR_THSY, ty);
        wr(PTAP_ADDR_THSZ, tz);
        wr(PTAP_ADDR_TMLT, 8'h05);
        wr(PTAP_ADDR_LTCY, 8'h01);
    endtask : setup

    task automatic t_reset();
        for (int a = 8'h21; a <= 8'h28; a++) begin
            rd(a[7:0], 8'h00, "reset value");
        end
        rd(8'h30, 8'h00, "unmapped read");
    endtask : t_reset

    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            wr(PTAP_ADDR_THSX + i[7:0], 8'hFF);
            rd(PTAP_ADDR_THSX + i[7:0], 8'h7F, "threshold rw");
        end
        wr(PTAP_ADDR_STATUS, 8'hFF);
        rd(PTAP_ADDR_STATUS, 8'h00, "status write");
    endtask : t_regs

    task automatic t_single();
        setup(8'h41, 8'h02, 8'h02, 8'h02);
        wr(PTAP_ADDR_IMASK, 8'h80);
        // exactly at the scaled threshold: no pulse starts
        smp(128, 0, 0);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h00, "at threshold");
        smp(129, 0, 0);
        smp(0, 0, 0);
        `CHK("irq on event", 1'b1, irq_o)
        rd(PTAP_ADDR_STATUS, 8'h90, "single x");
        rd(PTAP_ADDR_STATUS, 8'h00, "cleared by read");
        `CHK("irq after read", 1'b0, irq_o)
    endtask : t_single

    task automatic t_disabled();
        setup(8'h40, 8'h02, 8'h02, 8'h02);
        smp(2000, -2000, 2000);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h00, "enables off");
    endtask : t_disabled

    task automatic t_axes();
        setup(8'h55, 8'h02, 8'h10, 8'h02);
        // y stays just under its own higher threshold
        smp(3000, 1000, -3000);
        smp(0, 0, 0);
        `CHK("irq masked in", 1'b1, irq_o)
        wr(PTAP_ADDR_IMASK, 8'h00);
        #1;
        `CHK("irq masked out", 1'b0, irq_o)
        rd(PTAP_ADDR_STATUS, 8'hD4, "per axis");
        wr(PTAP_ADDR_IMASK, 8'h80);
    endtask : t_axes

    task automatic t_limit();
        setup(8'h41, 8'h02, 8'h02, 8'h02);
        wr(PTAP_ADDR_TMLT, 8'h02);
        repeat (4) smp(3000, 0, 0);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h00, "too long");
    endtask : t_limit

    task automatic t_double();
        setup(8'h48, 8'h02, 8'h02, 8'h02);
        smp(0, -3000, 0);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h00, "no single");
        smp(0, 0, 0);
        smp(0, 0, 0);
        smp(0, -3000, 0);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'hAA, "double y");
    endtask : t_double

    task automatic t_nolatch();
        setup(8'h01, 8'h02, 8'h02, 8'h02);
        smp(-3000, 0, 0);
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h91, "unlatched");
        smp(0, 0, 0);
        rd(PTAP_ADDR_STATUS, 8'h00, "next sample");
    endtask : t_nolatch

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        arst_n_i = 1'b0;
        sample_en_i = 1'b0;
        ax = '0;
        ay = '0;
        az = '0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1;
        `CHK("irq at reset", 1'b0, irq_o)
        t_reset();
        t_regs();
        t_single();
        t_disabled();
        t_axes();
        t_limit();
        t_double();
        t_nolatch();
        give_verdict();
    end
endmodule : ptap_top_test
